// *** src/twr_random_write.sv ***
// Random-write unit of a virtualization-aware translation buffer.
// Assumes an APB master on pclk; the pipeline command also arrives on pclk.
// Notes on behaviour
// - No coprocessor access: no write, unusable fault
// - No virtualization: reserved-instruction fault, no write
// - Random index selects entry; staging registers supply it
// - Size mismatch with split arrays: variable array
// - Optional duplicate detection on the write
// - Undetected duplicates left for lookup machine check
// - Detected duplicate invalidated, write completes, no check
// - Invalidate support: clear, then set from entry-invalidate
// - Copy mask, region, tag; page optionally masked
// - Root tagged write forces global, else AND
// - Frames optionally masked; cache, dirty, valid copied
// - Guest tag support stores root guest tag
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module twr_random_write
    import twr_pkg::*;
(
    input wire logic pclk, // Clock, 40 MHz
    input wire logic presetn, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error for unmapped offsets
    input wire logic write_random_instruction, // Pipeline command pulse
    output logic done_o, // Write completed pulse
    output logic cop_unusable_o, // Unusable fault pulse
    output logic reserved_instr_o, // Reserved-instruction fault pulse
    output logic irq // Level interrupt
);
    localparam int IDX_W = $clog2(FIX_ENTRIES);
    localparam int VIDX_W = $clog2(VAR_ENTRIES);
    localparam int HALF_W = PFN_W + CACHE_W + 2;

    logic [8:0] ctrl_r;
    logic [MASK_W-1:0] pmask_r;
    logic [31:0] ehi_r;
    logic [31:0] elo0_r;
    logic [31:0] elo1_r;
    logic [GID_W-1:0] gctl_r;
    logic [ST_W-1:0] stat_r;
    logic [ST_W-1:0] imask_r;
    logic [IDX_W-1:0] rand_r;
    logic [IDX_W-1:0] last_idx_r;
    logic last_var_r;
    logic cmd_sw_r;
    logic done_r;
    logic cpu_r;
    logic ri_r;
    logic dup_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic irq_r;

    logic acc;
    logic acc_wr;
    logic mapped;
    logic cmd;
    logic do_write;
    logic to_var;
    logic [VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] vpn_w;
    logic [PFN_W-1:0] pfn0_w;
    logic [PFN_W-1:0] pfn1_w;
    logic glob_w;
    logic hinv_w;
    logic [GID_W-1:0] gid_w;
    logic [2*HALF_W-1:0] halves_w;
    logic [VAR_ENTRIES-1:0] vdup;
    logic [FIX_ENTRIES-1:0] fdup;
    logic any_dup;
    logic [ST_W-1:0] ev;

    assign acc = psel && penable;
    // Writes land at the edge where the master sees pready, never earlier
    assign acc_wr = acc && pwrite && pready_r;
    assign mapped = paddr < OFS_LAST && paddr[1:0] == 2'b00;
    assign cmd = write_random_instruction || cmd_sw_r;

    assign do_write = cmd && ctrl_r[CT_COP_EN] && ctrl_r[CT_VZ];

    // Page size mismatch picks the variable array
    assign to_var = !ctrl_r[CT_SPLIT] || pmask_r != FIX_PAGE_MASK;

    assign vpn_w = ctrl_r[CT_ZMASK] ? (ehi_r[EH_VPN_LO +: VIRTUAL_PAGE_PAIR_NUMBER_W] & ~VIRTUAL_PAGE_PAIR_NUMBER_W'(pmask_r))
                                    : ehi_r[EH_VPN_LO +: VIRTUAL_PAGE_PAIR_NUMBER_W];
    assign pfn0_w = ctrl_r[CT_ZMASK] ? (elo0_r[EL_PFN_LO +: PFN_W] & ~PFN_W'(pmask_r))
                                     : elo0_r[EL_PFN_LO +: PFN_W];
    assign pfn1_w = ctrl_r[CT_ZMASK] ? (elo1_r[EL_PFN_LO +: PFN_W] & ~PFN_W'(pmask_r))
                                     : elo1_r[EL_PFN_LO +: PFN_W];
    assign halves_w = {pfn1_w, elo1_r[EL_C_LO +: CACHE_W], elo1_r[EL_D], elo1_r[EL_V],
                       pfn0_w, elo0_r[EL_C_LO +: CACHE_W], elo0_r[EL_D], elo0_r[EL_V]};

    assign glob_w = (ctrl_r[CT_G1] && !ctrl_r[CT_RAD] && ctrl_r[CT_ROOT] && gctl_r != '0)
                    || (elo0_r[EL_G] && elo1_r[EL_G]);

    assign hinv_w = ctrl_r[CT_IE] && ehi_r[EH_ENTRY_INVALIDATE_BIT];

    assign gid_w = ctrl_r[CT_G1] ? gctl_r : '0;

    assign any_dup = ctrl_r[CT_MM_EN] && ((to_var && |vdup) || (!to_var && |fdup));

    twr_entry_array #(
        .ENTRIES(VAR_ENTRIES),
        .IW(VIDX_W)
    ) u_var (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(do_write && to_var),
        .wr_idx(rand_r[VIDX_W-1:0]),
        .wr_vpn(vpn_w),
        .wr_region(ehi_r[EH_R_LO +: REGION_W]),
        .wr_address_space_tag(ehi_r[EH_ADDRESS_SPACE_TAG_LO +: ADDRESS_SPACE_TAG_W]),
        .wr_mask(pmask_r),
        .wr_glob(glob_w),
        .wr_gid(gid_w),
        .wr_hinv(hinv_w),
        .wr_halves(halves_w),
        .dup_kill(do_write && to_var && ctrl_r[CT_MM_EN]),
        .dup_vec(vdup),
        .hinv_vec()
    );

    twr_entry_array #(
        .ENTRIES(FIX_ENTRIES),
        .IW(IDX_W)
    ) u_fix (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(do_write && !to_var),
        .wr_idx(rand_r),
        .wr_vpn(vpn_w),
        .wr_region(ehi_r[EH_R_LO +: REGION_W]),
        .wr_address_space_tag(ehi_r[EH_ADDRESS_SPACE_TAG_LO +: ADDRESS_SPACE_TAG_W]),
        .wr_mask(pmask_r),
        .wr_glob(glob_w),
        .wr_gid(gid_w),
        .wr_hinv(hinv_w),
        .wr_halves(halves_w),
        .dup_kill(do_write && !to_var && ctrl_r[CT_MM_EN]),
        .dup_vec(fdup),
        .hinv_vec()
    );

    // Random index steps every cycle, never stalls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rand_r <= '1;
        end else begin
            rand_r <= rand_r - IDX_W'(1);
        end
    end

    // Duplicate invalidated, write completes without check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
            cpu_r <= 1'b0;
            ri_r <= 1'b0;
            dup_r <= 1'b0;
            last_idx_r <= '0;
            last_var_r <= 1'b0;
        end else begin
            done_r <= do_write;
            cpu_r <= cmd && !ctrl_r[CT_COP_EN];
            ri_r <= cmd && ctrl_r[CT_COP_EN] && !ctrl_r[CT_VZ];
            dup_r <= do_write && any_dup;
            if (do_write) begin
                last_idx_r <= to_var ? IDX_W'(rand_r[VIDX_W-1:0]) : rand_r;
                last_var_r <= to_var;
            end
        end
    end

    assign ev = {dup_r, ri_r, cpu_r, done_r};

    // Status set wins over a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~((acc_wr && paddr == OFS_STAT) ? pwdata[ST_W-1:0] : '0)) | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & imask_r);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= '0;
            pmask_r <= '0;
            ehi_r <= '0;
            elo0_r <= '0;
            elo1_r <= '0;
            gctl_r <= '0;
            imask_r <= '0;
            cmd_sw_r <= 1'b0;
        end else begin
            cmd_sw_r <= acc_wr && paddr == OFS_CMD && pwdata[0];
            if (acc_wr) begin
                case (paddr)
                    OFS_CTRL: ctrl_r <= pwdata[8:0];
                    OFS_PMASK: pmask_r <= pwdata[MASK_W-1:0];
                    OFS_EHI: ehi_r <= pwdata;
                    OFS_ELO0: elo0_r <= pwdata;
                    OFS_ELO1: elo1_r <= pwdata;
                    OFS_GCTL: gctl_r <= pwdata[GID_W-1:0];
                    OFS_IMASK: imask_r <= pwdata[ST_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // One wait state: ready the cycle after the access phase opens
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= acc && !pready_r;
            pslverr_r <= acc && !pready_r && !mapped;
            prdata_r <= '0;
            if (acc && !pready_r && !pwrite) begin
                case (paddr)
                    OFS_CTRL: prdata_r <= {23'h000000, ctrl_r};
                    OFS_PMASK: prdata_r <= {16'h0000, pmask_r};
                    OFS_EHI: prdata_r <= ehi_r;
                    OFS_ELO0: prdata_r <= elo0_r;
                    OFS_ELO1: prdata_r <= elo1_r;
                    OFS_GCTL: prdata_r <= {24'h000000, gctl_r};
                    OFS_STAT: prdata_r <= {28'h0000000, stat_r};
                    OFS_IMASK: prdata_r <= {28'h0000000, imask_r};
                    OFS_CMD: prdata_r <= {21'h000000, last_var_r, last_idx_r, rand_r};
                    default: prdata_r <= '0;
                endcase
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign done_o = done_r;
    assign cop_unusable_o = cpu_r;
    assign reserved_instr_o = ri_r;
    assign irq = irq_r;
endmodule : twr_random_write

// *** src/twr_pkg.sv ***
// Package for the random-write unit of the translation buffer.
// Assumes a single pclk domain and an APB register port.
package twr_pkg;
    localparam int ENTRY_IDX_W = 6;
    localparam int VIRTUAL_PAGE_PAIR_NUMBER_W = 19;
    localparam int ADDRESS_SPACE_TAG_W = 8;
    localparam int REGION_W = 2;
    localparam int PFN_W = 20;
    localparam int MASK_W = 16;
    localparam int GID_W = 8;
    localparam int CACHE_W = 3;
    localparam int VAR_ENTRIES = 16;
    localparam int FIX_ENTRIES = 32;
    localparam logic [MASK_W-1:0] FIX_PAGE_MASK = 16'h0000;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PMASK = 8'h04;
    localparam logic [7:0] OFS_EHI = 8'h08;
    localparam logic [7:0] OFS_ELO0 = 8'h0C;
    localparam logic [7:0] OFS_ELO1 = 8'h10;
    localparam logic [7:0] OFS_GCTL = 8'h14;
    localparam logic [7:0] OFS_CMD = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1C;
    localparam logic [7:0] OFS_IMASK = 8'h20;
    localparam logic [7:0] OFS_LAST = 8'h24;
    // Control register bit positions
    localparam int CT_COP_EN = 0;
    localparam int CT_VZ = 1;
    localparam int CT_IE = 2;
    localparam int CT_G1 = 3;
    localparam int CT_RAD = 4;
    localparam int CT_ROOT = 5;
    localparam int CT_MM_EN = 6;
    localparam int CT_ZMASK = 7;
    localparam int CT_SPLIT = 8;
    // Entry high layout
    localparam int EH_ADDRESS_SPACE_TAG_LO = 0;
    localparam int EH_ENTRY_INVALIDATE_BIT = 10;
    localparam int EH_VPN_LO = 11;
    localparam int EH_R_LO = 30;
    // Entry low layout
    localparam int EL_G = 0;
    localparam int EL_V = 1;
    localparam int EL_D = 2;
    localparam int EL_C_LO = 3;
    localparam int EL_PFN_LO = 6;
    // Status bits
    localparam int ST_DONE = 0;
    localparam int ST_CPU = 1;
    localparam int ST_RI = 2;
    localparam int ST_DUP = 3;
    localparam int ST_W = 4;
endpackage : twr_pkg

// *** src/twr_entry_array.sv ***
// Flip-flop storage for one translation array with a duplicate search.
// Assumes one write per cycle from the random-write unit in the same domain.
`timescale 1ns/1ps
module twr_entry_array
    import twr_pkg::*;
#(
    parameter int ENTRIES = 16,
    parameter int IW = 6
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, low
    input wire logic wr_en, // Write the entry at wr_idx
    input wire logic [IW-1:0] wr_idx, // Entry to write
    input wire logic [VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] wr_vpn, // Virtual page pair
    input wire logic [REGION_W-1:0] wr_region, // Region
    input wire logic [ADDRESS_SPACE_TAG_W-1:0] wr_address_space_tag, // Address space tag
    input wire logic [MASK_W-1:0] wr_mask, // Page mask
    input wire logic wr_glob, // Global
    input wire logic [GID_W-1:0] wr_gid, // Guest tag
    input wire logic wr_hinv, // Hardware invalid flag
    input wire logic [2*(PFN_W+CACHE_W+2)-1:0] wr_halves, // Odd and even half data
    input wire logic dup_kill, // Invalidate the entries flagged in dup_vec
    output logic [ENTRIES-1:0] dup_vec, // Entries matching the write key
    output logic [ENTRIES-1:0] hinv_vec // Hardware invalid flags
);
    localparam int HW = 2*(PFN_W+CACHE_W+2);
    logic [VIRTUAL_PAGE_PAIR_NUMBER_W-1:0] vpn_r [ENTRIES];
    logic [REGION_W-1:0] region_r [ENTRIES];
    logic [ADDRESS_SPACE_TAG_W-1:0] address_space_tag_r [ENTRIES];
    logic [MASK_W-1:0] mask_r [ENTRIES];
    logic [GID_W-1:0] gid_r [ENTRIES];
    logic [HW-1:0] halves_r [ENTRIES];
    logic glob_r [ENTRIES];
    logic hinv_r [ENTRIES];

    genvar e;
    generate
        for (e = 0; e < ENTRIES; e++) begin : g_ent
            logic hit;
            // Match ignores masked page bits; global entries match any tag
            assign hit = !hinv_r[e] && region_r[e] == wr_region && gid_r[e] == wr_gid
                && ((vpn_r[e] & ~VIRTUAL_PAGE_PAIR_NUMBER_W'(mask_r[e] | wr_mask)) == (wr_vpn & ~VIRTUAL_PAGE_PAIR_NUMBER_W'(mask_r[e] | wr_mask)))
                && (glob_r[e] || wr_glob || address_space_tag_r[e] == wr_address_space_tag);
            assign dup_vec[e] = hit && !(wr_idx == IW'(e));
            assign hinv_vec[e] = hinv_r[e];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    vpn_r[e] <= '0;
                    region_r[e] <= '0;
                    address_space_tag_r[e] <= '0;
                    mask_r[e] <= '0;
                    gid_r[e] <= '0;
                    halves_r[e] <= '0;
                    glob_r[e] <= 1'b0;
                    hinv_r[e] <= 1'b1;
                end else if (wr_en && wr_idx == IW'(e)) begin
                    vpn_r[e] <= wr_vpn;
                    region_r[e] <= wr_region;
                    address_space_tag_r[e] <= wr_address_space_tag;
                    mask_r[e] <= wr_mask;
                    gid_r[e] <= wr_gid;
                    halves_r[e] <= wr_halves;
                    glob_r[e] <= wr_glob;
                    hinv_r[e] <= wr_hinv;
                end else if (dup_kill && dup_vec[e]) begin
                    hinv_r[e] <= 1'b1;
                end
            end
        end
    endgenerate
endmodule : twr_entry_array

// *** testbench/twr_asserts.sv ***
// Checker for the random-write unit, watching only its top ports.
// Assumes control, page-mask and interrupt-mask registers reset to zero.
`timescale 1ns/1ps
module twr_checker
    import twr_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic write_random_instruction, // Pipeline command
    input wire logic done_o, // Write completed
    input wire logic cop_unusable_o, // Unusable fault
    input wire logic reserved_instr_o, // Reserved-instruction fault
    input wire logic irq // Level interrupt
);
    logic [8:0] ctrl_r;
    logic [3:0] imask_r;
    logic [MASK_W-1:0] pmask_r;
    logic lastvar_r;
    logic seen_r;
    logic wr_hit;
    assign wr_hit = psel && penable && pready && pwrite && !pslverr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of the setup the unit acts on, updated at the write edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= '0;
            imask_r <= '0;
            pmask_r <= '0;
        end else if (wr_hit) begin
            case (paddr)
                OFS_CTRL: ctrl_r <= pwdata[8:0];
                OFS_PMASK: pmask_r <= pwdata[MASK_W-1:0];
                OFS_IMASK: imask_r <= pwdata[3:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lastvar_r <= 1'b0;
            seen_r <= 1'b0;
        end else if (write_random_instruction && ctrl_r[CT_COP_EN] && ctrl_r[CT_VZ]) begin
            lastvar_r <= !ctrl_r[CT_SPLIT] || (pmask_r != FIX_PAGE_MASK);
            seen_r <= 1'b1;
        end
    end
    chk_cop_fault:
    assert property (write_random_instruction && !ctrl_r[CT_COP_EN] |=> cop_unusable_o && !done_o)
        else $error("unusable fault missing");
    chk_vz_fault:
    assert property (write_random_instruction && ctrl_r[CT_COP_EN] && !ctrl_r[CT_VZ] |=> reserved_instr_o && !done_o)
        else $error("reserved fault missing");
    chk_write_done:
    assert property (write_random_instruction && ctrl_r[CT_COP_EN] && ctrl_r[CT_VZ] |=> done_o)
        else $error("write completion missing");
    chk_one_result:
    assert property ($onehot0({done_o, cop_unusable_o, reserved_instr_o}))
        else $error("two results at once");
    chk_array_route:
    assert property (pready && !pwrite && !pslverr && paddr == OFS_CMD && seen_r
        |-> prdata[10] == lastvar_r && (!lastvar_r || !prdata[9]))
        else $error("wrong array chosen");
    chk_ready_wait:
    assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("ready not after one wait state");
    chk_ready_pulse:
    assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_slverr_map:
    assert property (pready |-> pslverr == (paddr >= OFS_LAST || paddr[1:0] != 2'b00))
        else $error("error response wrong");
    chk_unmapped_zero:
    assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_irq_raise:
    assert property ((done_o && imask_r[ST_DONE]) || (cop_unusable_o && imask_r[ST_CPU]) |-> ##2 irq)
        else $error("interrupt not raised");
    chk_irq_masked:
    assert property (imask_r == 4'h0 && $past(imask_r) == 4'h0 |-> !irq)
        else $error("interrupt while fully masked");
endmodule : twr_checker

bind twr_random_write twr_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .write_random_instruction(write_random_instruction), .done_o(done_o),
    .cop_unusable_o(cop_unusable_o), .reserved_instr_o(reserved_instr_o), .irq(irq)
);

// *** testbench/twr_pipe_model.sv ***
// Pipeline model that issues random-write commands to the unit.
// Assumes its task is called just after a rising edge of pclk.
`timescale 1ns/1ps
module twr_pipe_model (
    input wire logic pclk, // Clock
    output logic write_random_instruction // Command pulse
);
    initial write_random_instruction = 1'b0;
    // Idle for gap cycles, then n commands back to back
    task automatic fire(input int gap, input int n);
        repeat (gap) @(posedge pclk);
        write_random_instruction <= 1'b1;
        repeat (n) @(posedge pclk);
        write_random_instruction <= 1'b0;
    endtask : fire
endmodule : twr_pipe_model

// *** testbench/tlb_random_write_bench.sv ***
// Self-checking bench for the random-write unit.
// Assumes the checker is bound by its own file and the pipeline model drives commands.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tlb_random_write_bench
    import twr_pkg::*;
;
    typedef struct {string nm; logic [31:0] msk; logic [31:0] val; logic err;} twr_exp_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic write_random_instruction, done_o, cop_unusable_o, reserved_instr_o;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] ev;
    int n_fail, check_count, cyc, seed;
    twr_exp_t x;
    twr_exp_t rd_q[$];
    logic [2:0] ev_q[$];
    logic [8:0] rt_ctrl[3] = '{9'h103, 9'h103, 9'h003};
    logic [15:0] rt_mask[3] = '{16'h0003, 16'h0000, 16'h0000};
    logic rt_var[3] = '{1'b1, 1'b0, 1'b1};
    twr_random_write DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .write_random_instruction(write_random_instruction), .done_o(done_o),
        .cop_unusable_o(cop_unusable_o), .reserved_instr_o(reserved_instr_o), .irq(irq));
    twr_pipe_model pipe (.pclk(pclk), .write_random_instruction(write_random_instruction));
    always #12.5 pclk = ~pclk;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, input logic e);
        rd_q.push_back('{nm, m, v, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd
    task automatic cmd(input logic [2:0] e, input int gap, input int n);
        repeat (n) ev_q.push_back(e);
        pipe.fire(gap, n);
        repeat (2) @(posedge pclk);
    endtask : cmd
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // Reads and command results are taken off the queues as they appear
    always @(posedge pclk) begin
        cyc++;
        if (cyc >= 5000) begin
            n_fail++;
            wrap_up();
        end else begin
            if ((psel && penable && !pwrite && pready) === 1'b1) begin
                if (rd_q.size() > 0)
                    x = rd_q.pop_front();
                else
                    x = '{"stray read", 32'h0, 32'h1, 1'b0};
                `CHK(x.nm, x.val, prdata & x.msk)
                `CHK("pslverr", x.err, pslverr)
            end
            if ((done_o | cop_unusable_o | reserved_instr_o) === 1'b1) begin
                ev = ev_q.size() > 0 ? ev_q.pop_front() : 3'b000;
                `CHK("result", ev, {done_o, cop_unusable_o, reserved_instr_o})
            end
        end
    end
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        seed = 23;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd("status reset", OFS_STAT, 32'h0000_000F, 32'h0, 1'b0);
        `CHK("irq reset", 1'b0, irq)
        apb(1'b1, 8'h28, 32'hFFFF_FFFF);
        rd("unmapped", OFS_LAST, 32'hFFFF_FFFF, 32'h0, 1'b1);
        rd("unaligned", 8'h06, 32'hFFFF_FFFF, 32'h0, 1'b1);
        $display("test reset and map done");
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        cmd(3'b010, 0, 1);
        rd("status unusable", OFS_STAT, 32'h0000_000F, 32'h2, 1'b0);
        apb(1'b1, OFS_STAT, 32'h0000_000F);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        cmd(3'b001, 3, 2);
        rd("status reserved", OFS_STAT, 32'h0000_000F, 32'h4, 1'b0);
        apb(1'b1, OFS_STAT, 32'h0000_000F);
        $display("test faults done");
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFS_CTRL, {23'h0, rt_ctrl[i]});
            apb(1'b1, OFS_PMASK, {16'h0, rt_mask[i]});
            apb(1'b1, OFS_EHI, $random(seed));
            apb(1'b1, OFS_ELO0, $random(seed));
            apb(1'b1, OFS_ELO1, $random(seed));
            cmd(3'b100, i, 1);
            rd("array route", OFS_CMD, 32'h0000_0400, {21'h0, rt_var[i], 10'h0}, 1'b0);
        end
        $display("test array routing done");
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, OFS_STAT, 32'h0000_000F);
            apb(1'b1, OFS_CTRL, i ? 32'h0000_007B : 32'h0000_006B);
            apb(1'b1, OFS_GCTL, 32'h0000_005A);
            apb(1'b1, OFS_PMASK, 32'h0000_0000);
            apb(1'b1, OFS_ELO0, $random(seed) & 32'hFFFF_FFFE);
            apb(1'b1, OFS_ELO1, $random(seed) & 32'hFFFF_FFFE);
            apb(1'b1, OFS_EHI, {2'b00, i ? 19'h2468A : 19'h1234A, 1'b0, 2'b00, 8'h11});
            cmd(3'b100, 0, 1);
            apb(1'b1, OFS_EHI, {2'b00, i ? 19'h2468A : 19'h1234A, 1'b0, 2'b00, 8'h22});
            cmd(3'b100, 0, 1);
            rd("duplicate", OFS_STAT, 32'h0000_0008, i ? 32'h0 : 32'h8, 1'b0);
        end
        $display("test duplicates done");
        // Flagged entry must not count as a match; the software command then matches the valid second copy
        apb(1'b1, OFS_STAT, 32'h0000_000F);
        apb(1'b1, OFS_CTRL, 32'h0000_0047);
        apb(1'b1, OFS_EHI, {2'b01, 19'h3579B, 1'b1, 2'b00, 8'h33});
        cmd(3'b100, 0, 1);
        apb(1'b1, OFS_EHI, {2'b01, 19'h3579B, 1'b0, 2'b00, 8'h33});
        cmd(3'b100, 0, 1);
        rd("flagged entry", OFS_STAT, 32'h0000_0008, 32'h0, 1'b0);
        ev_q.push_back(3'b100);
        apb(1'b1, OFS_CMD, 32'h0000_0001);
        rd("valid entry", OFS_STAT, 32'h0000_0008, 32'h8, 1'b0);
        $display("test invalidate flag done");
        apb(1'b1, OFS_STAT, 32'h0000_000F);
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        apb(1'b1, OFS_IMASK, 32'h0000_0002);
        cmd(3'b010, 0, 1);
        @(posedge pclk);
        `CHK("irq raised", 1'b1, irq)
        apb(1'b1, OFS_IMASK, 32'h0000_0000);
        @(posedge pclk);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, OFS_IMASK, 32'h0000_0002);
        @(posedge pclk);
        `CHK("irq unmasked", 1'b1, irq)
        apb(1'b1, OFS_STAT, 32'h0000_0002);
        @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        $display("test interrupt done");
        `CHK("pending notes", 0, rd_q.size() + ev_q.size())
        wrap_up();
    end
endmodule : tlb_random_write_bench
